// ===== src/asmx_map.vh
`ifndef ASMX_MAP_VH
`define ASMX_MAP_VH
`define ASMX_CLK_NS 40
`define ASMX_ADDR_W 17
`define ASMX_DATA_W 32
`define ASMX_LANES 4
// Least times for the slowest grade, in ns
`define ASMX_T_ADDR_TO_WEND_NS 20
`define ASMX_T_SEL_TO_WEND_NS 20
`define ASMX_T_ADDR_HOLD_NS 0
`define ASMX_T_READ_ACCESS_NS 35
`define ASMX_T_READ_HOLD_NS 5
`define ASMX_T_DESEL_TO_RET_NS 0
`define ASMX_T_RECOVERY_NS 35
`define ASMX_CEIL_CYC(ns) (((ns) + `ASMX_CLK_NS - 1) / `ASMX_CLK_NS)
`define ASMX_MIN1(c) (((c) < 1) ? 1 : (c))
`define ASMX_WR_CYC `ASMX_MIN1(`ASMX_CEIL_CYC(`ASMX_T_ADDR_TO_WEND_NS))
`define ASMX_RD_CYC `ASMX_MIN1(`ASMX_CEIL_CYC(`ASMX_T_READ_ACCESS_NS))
`define ASMX_RET_CYC `ASMX_MIN1(`ASMX_CEIL_CYC(`ASMX_T_DESEL_TO_RET_NS))
`define ASMX_REC_CYC `ASMX_MIN1(`ASMX_CEIL_CYC(`ASMX_T_RECOVERY_NS))
`endif

// ===== src/asmx_timer.v
`timescale 1ns/1ps
`default_nettype none
module asmx_timer
(
   input wire clk,
   input wire resetn,
   input wire load,
   input wire [3:0] count,
   output wire done
);
   reg [3:0] cnt_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt_r <= 4'h0;
      else if (load)
         cnt_r <= count;
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end
   assign done = (cnt_r == 4'h1) && !load;
endmodule // asmx_timer
`default_nettype wire

// ===== src/asmx_ctrl.v
// Behaviour
// (RULE1) Write when strobe and select both low
// (RULE2) Module drives data on read selection
// (RULE3) Bus floats when deselected or output off
// (RULE4) Four lane selects gate each byte
// (RULE5) Write bounded by last assert, first deassert
// (RULE6) Address valid long enough before write end
// (RULE7) Select asserted long enough before write end
// (RULE8) Address may change right after write
// (RULE9) Module holds read data after address change
// (RULE10) Address valid by last lane select
// (RULE11) Deselect module before entering retention
// (RULE12) Density id pins left unconnected
// (RULE13) Release bus before read; strobe high
`timescale 1ns/1ps
`default_nettype none
`include "asmx_map.vh"
module asmx_ctrl
(
   input wire clk,
   input wire resetn,
   input wire req_valid,
   input wire req_write,
   input wire [16:0] req_addr,
   input wire [31:0] req_wdata,
   input wire [3:0] req_lanes,
   input wire ret_req,
   input wire [31:0] data_bus_in,
   input wire density_id0,
   input wire density_id1,
   output reg req_ready,
   output reg rsp_valid,
   output reg [31:0] rsp_rdata,
   output reg ret_active,
   output reg [1:0] density_code,
   output reg [16:0] word_address,
   output reg write_strobe_n,
   output reg output_drive_n,
   output reg byte0_select_n,
   output reg byte1_select_n,
   output reg byte2_select_n,
   output reg byte3_select_n,
   output reg [31:0] data_bus_out,
   output reg data_bus_oe
);
   // Binary state codes; any unused code falls back to idle
   localparam ST_IDLE = 3'h0;
   localparam ST_WRITE = 3'h1;
   localparam ST_WEND = 3'h2;
   localparam ST_READ = 3'h3;
   localparam ST_RET = 3'h4;
   localparam ST_REC = 3'h5;
   localparam ST_RDONE = 3'h6;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   // Lanes are held for the whole access, so the request pins may move freely
   reg [3:0] lanes_r;
   reg ld;
   reg [3:0] ld_cnt;
   wire t_done;

   // Every span fits four bits at this clock, so the cut is deliberate
   function [3:0] cyc4;
      input integer c;
      begin
         cyc4 = c[3:0];
      end
   endfunction

   // One shared down-counter times the write, read and recovery spans
   asmx_timer u_timer
   (
      .clk(clk),
      .resetn(resetn),
      .load(ld),
      .count(ld_cnt),
      .done(t_done)
   );

   always @*
   begin
      state_nxt = state_r;
      ld = 1'b0;
      ld_cnt = 4'h0;
      // Retention is checked first in idle so that a new request never holds off a pending supply drop
      case (state_r)
         ST_IDLE:
         begin
            if (ret_req)
            begin
               state_nxt = ST_RET;
               ld = 1'b1;
               ld_cnt = cyc4(`ASMX_RET_CYC); // see (RULE11)
            end
            else if (req_valid && req_write)
            begin
               state_nxt = ST_WRITE;
               ld = 1'b1;
               ld_cnt = cyc4(`ASMX_WR_CYC); // see (RULE6)
            end
            else if (req_valid)
            begin
               state_nxt = ST_READ;
               ld = 1'b1;
               ld_cnt = cyc4(`ASMX_RD_CYC);
            end
         end
         ST_WRITE:
            if (t_done)
               state_nxt = ST_WEND;
         ST_WEND:
            state_nxt = ST_IDLE;
         ST_READ:
            if (t_done)
               state_nxt = ST_RDONE;
         ST_RDONE:
            // Spare cycle lets the module's outputs turn off before the next access
            state_nxt = ST_IDLE;
         ST_RET:
            if (!ret_req)
            begin
               state_nxt = ST_REC;
               ld = 1'b1;
               ld_cnt = cyc4(`ASMX_REC_CYC);
            end
         // Recovery span before the first access after retention
         ST_REC:
            if (t_done)
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= ST_IDLE;
         lanes_r <= 4'h0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 32'h0;
         ret_active <= 1'b0;
         density_code <= 2'h0;
         word_address <= 17'h0;
         write_strobe_n <= 1'b1;
         output_drive_n <= 1'b1;
         byte0_select_n <= 1'b1;
         byte1_select_n <= 1'b1;
         byte2_select_n <= 1'b1;
         byte3_select_n <= 1'b1;
         data_bus_out <= 32'h0;
         data_bus_oe <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         // Pins float when unconnected; the board pulls them up
         density_code <= {density_id1, density_id0}; // see (RULE12)
         // A retention request withdraws ready on the next edge, the same edge on which idle takes it ahead of any access
         req_ready <= (state_nxt == ST_IDLE) && !ret_req;
         rsp_valid <= 1'b0;
         ret_active <= (state_nxt == ST_RET);
         if (state_r == ST_IDLE && state_nxt != ST_IDLE)
         begin
            // Address and lanes in the same edge, selects never lead the address
            word_address <= req_addr; // see (RULE10)
            lanes_r <= req_lanes;
         end
         case (state_nxt)
            ST_WRITE:
            begin
               // Strobe and selects assert together and stay for the whole count
               // Address setup is zero, so the address and the strobe may move together
               write_strobe_n <= 1'b0; // see (RULE1)
               output_drive_n <= 1'b1;
               {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n} <=
                  ~((state_r == ST_IDLE) ? req_lanes : lanes_r); // see (RULE4) (RULE7)
               if (state_r == ST_IDLE)
                  data_bus_out <= req_wdata;
               data_bus_oe <= 1'b1;
            end
            ST_WEND:
            begin
               // Strobe and selects release on one edge; data held one more cycle
               write_strobe_n <= 1'b1; // see (RULE5)
               {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n} <= 4'hf;
               data_bus_oe <= 1'b1;
            end
            ST_READ:
            begin
               // The bus was released at least one idle cycle earlier, so no drive fight
               write_strobe_n <= 1'b1; // see (RULE13)
               data_bus_oe <= 1'b0;
               output_drive_n <= 1'b0; // see (RULE2)
               {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n} <=
                  ~((state_r == ST_IDLE) ? req_lanes : lanes_r); // see (RULE4)
            end
            default:
            begin
               // Deselected: module floats its outputs and may enter retention
               write_strobe_n <= 1'b1;
               output_drive_n <= 1'b1; // see (RULE3)
               {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n} <=
                  4'hf; // see (RULE11)
               data_bus_oe <= 1'b0;
            end
         endcase
         // Limitation: one word per access, paced by the slowest grade
         if (state_r == ST_READ && t_done)
         begin
            // Sample before address moves; only the module's hold covers skew
            rsp_rdata <= data_bus_in; // see (RULE9)
            rsp_valid <= 1'b1;
         end
         // Address is kept after a write and only changes when idle is next left, for a request or for retention
         if (state_r == ST_WEND)
            word_address <= word_address; // see (RULE8)
      end
   end
endmodule // asmx_ctrl
`default_nettype wire

// ===== dv/asmx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asmx_properties
(
   input wire clk,
   input wire resetn,
   input wire rsp_valid,
   input wire req_ready,
   input wire ret_active,
   input wire [16:0] word_address,
   input wire write_strobe_n,
   input wire output_drive_n,
   input wire byte0_select_n,
   input wire byte1_select_n,
   input wire byte2_select_n,
   input wire byte3_select_n,
   input wire data_bus_oe
);
   wire [3:0] sel_n = {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_WR_DRV: assert property (!write_strobe_n |-> data_bus_oe && output_drive_n)
      else $error("write without bus drive");
   AST_WR_SEL: assert property (!write_strobe_n |-> sel_n != 4'hf)
      else $error("write without lane select");
   AST_WR_END: assert property ($rose(write_strobe_n) |-> &sel_n)
      else $error("select outlives strobe");
   AST_WR_LEN: assert property ($fell(write_strobe_n) |=> write_strobe_n && data_bus_oe ##1 !data_bus_oe)
      else $error("write length wrong");
   AST_RD_QUIET: assert property (!output_drive_n |-> !data_bus_oe && write_strobe_n)
      else $error("bus driven during read");
   AST_RD_ADDR: assert property (!output_drive_n |=> $stable(word_address))
      else $error("address moved during read");
   AST_RD_RSP: assert property ($fell(output_drive_n) |->
      ##1 rsp_valid && output_drive_n ##1 req_ready)
      else $error("read answer late");
   AST_RET: assert property (ret_active |-> &sel_n)
      else $error("selected in retention");
   cover property ($fell(write_strobe_n));
   cover property (rsp_valid);
   cover property (ret_active);
endmodule // asmx_properties
bind asmx_ctrl asmx_properties u_props (.clk(clk), .resetn(resetn), .rsp_valid(rsp_valid),
   .req_ready(req_ready), .ret_active(ret_active), .word_address(word_address),
   .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
   .byte0_select_n(byte0_select_n), .byte1_select_n(byte1_select_n),
   .byte2_select_n(byte2_select_n), .byte3_select_n(byte3_select_n),
   .data_bus_oe(data_bus_oe));
`default_nettype wire

// ===== dv/asmx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module asmx_mem
(
   input wire logic [16:0] word_address,
   input wire logic write_strobe_n,
   input wire logic output_drive_n,
   input wire logic [3:0] sel_n,
   input wire logic [31:0] dq_in,
   output logic [31:0] dq_out,
   output logic density_id0,
   output logic density_id1
);
   logic [31:0] mem [0:131071];
   logic [31:0] last = 32'h0;
   wire [31:0] word = mem[word_address];
   wire [31:0] m = {{8{sel_n[3]}}, {8{sel_n[2]}}, {8{sel_n[1]}}, {8{sel_n[0]}}};
   // Open pins read high through host pull-ups
   assign density_id0 = 1'b1;
   assign density_id1 = 1'b1;
   always @*
      for (int i = 0; i < 4; i++)
         if (!sel_n[i] && !write_strobe_n) mem[word_address][8*i+:8] = dq_in[8*i+:8];
   // Idle lanes show the inverse of old data so a stale sample cannot pass
   assign #5 dq_out = (!output_drive_n && write_strobe_n) ? (word & ~m | ~last & m) : ~last;
   always @(posedge output_drive_n) last = dq_out;
endmodule // asmx_mem
`default_nettype wire

// ===== dv/asmx_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asmx_ctrl_tb;
   logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0, ret_req = 1'b0;
   logic [16:0] req_addr = 17'h0;
   logic [31:0] req_wdata = 32'h0;
   logic [3:0] req_lanes = 4'h0;
   int n_errors = 0, cmp_count = 0;
   wire req_ready, rsp_valid, ret_active, write_strobe_n, output_drive_n, data_bus_oe;
   wire byte0_select_n, byte1_select_n, byte2_select_n, byte3_select_n, density_id0, density_id1;
   wire [1:0] density_code;
   wire [16:0] word_address;
   wire [31:0] rsp_rdata, data_bus_out, q;
   wire [31:0] data_bus_in = data_bus_oe ? data_bus_out : q;
   wire [3:0] sel_n = {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n};
   asmx_ctrl u_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes), .ret_req(ret_req),
      .data_bus_in(data_bus_in), .density_id0(density_id0), .density_id1(density_id1),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .ret_active(ret_active), .density_code(density_code), .word_address(word_address),
      .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
      .byte0_select_n(byte0_select_n), .byte1_select_n(byte1_select_n),
      .byte2_select_n(byte2_select_n), .byte3_select_n(byte3_select_n),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
   asmx_mem u_mem (.word_address(word_address), .write_strobe_n(write_strobe_n),
      .output_drive_n(output_drive_n), .sel_n(sel_n), .dq_in(data_bus_in), .dq_out(q),
      .density_id0(density_id0), .density_id1(density_id1));
   always #20 clk = ~clk;
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, s, e);
      end
   endtask
   // Called at a falling edge; for a read d is the expected word
   task go(input logic w, input logic [16:0] a, input logic [31:0] d, input logic [3:0] l);
      int n;
      logic [31:0] m;
      m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
      {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
      for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (n = 0; n < 20 && (w ? req_ready : rsp_valid) !== 1'b1; n++) @(negedge clk);
      chk(n < 20, 1);
      if (!w) chk(rsp_rdata & m, d & m);
   endtask
   task t_lanes;
      go(1, 17'h1ffff, 32'h0, 4'hf);
      for (int i = 0; i < 4; i++) go(1, 17'h1ffff, 32'ha3a2a1a0, 4'h1 << i);
      for (int i = 0; i < 4; i++) go(0, 17'h1ffff, 32'ha3a2a1a0, 4'h1 << i);
      go(1, 17'h1ffff, 32'hffffffff, 4'h5);
      go(0, 17'h1ffff, 32'ha3ffa1ff, 4'hf);
      $display("lanes done");
   endtask
   task t_b2b;
      go(1, 17'h0, 32'h12345678, 4'hf);
      go(0, 17'h0, 32'h12345678, 4'hf);
      go(1, 17'h1, 32'hcafe0001, 4'hf);
      go(0, 17'h0, 32'h12345678, 4'hf);
      go(0, 17'h1, 32'hcafe0001, 4'hf);
      $display("back to back done");
   endtask
   task t_ret;
      int n;
      // The last read may still be closing; retention is only taken from idle
      for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk);
      ret_req = 1'b1;
      @(negedge clk);
      chk(ret_active, 1);
      chk(sel_n, 4'hf);
      chk(req_ready, 0);
      ret_req = 1'b0;
      go(0, 17'h0, 32'h12345678, 4'hf);
      $display("retention done");
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      chk(density_code, 2'h3);
      chk(req_ready, 1);
      chk({sel_n, write_strobe_n, output_drive_n, data_bus_oe}, 7'h7e);
      t_lanes;
      t_b2b;
      t_ret;
      test_done;
   end
   initial
   begin
      #100000;
      n_errors++;
      test_done;
   end
endmodule // asmx_ctrl_tb
`default_nettype wire
